// ---- flash_seq_pkg.sv ----
// package: constants for the flash program/erase sequencer
package flash_seq_pkg;
	localparam int          CLK_MHZ        = 100;
	localparam int          WINDOW_US      = 120;
	localparam int          WINDOW_CYC     = WINDOW_US * CLK_MHZ;
	localparam int          SUSP_NS        = 100;
	localparam int          SUSP_CYC       = (SUSP_NS * CLK_MHZ + 999) / 1000;
	localparam int          PROG_CYC_DEF   = 1000;
	localparam int          ERASE_CYC_DEF  = 20000;
	localparam int          PROG_LIMIT_DEF = 100000;
	localparam logic [11:0] ADDR_UNLOCK1   = 12'h555;
	localparam logic [11:0] ADDR_UNLOCK2   = 12'haaa;
	localparam logic [7:0]  CODE_UNLOCK1   = 8'haa;
	localparam logic [7:0]  CODE_UNLOCK2   = 8'h55;
	localparam logic [7:0]  CODE_BYPASS    = 8'h20;
	localparam logic [7:0]  CODE_PROGRAM   = 8'ha0;
	localparam logic [7:0]  CODE_ERASE     = 8'h80;
	localparam logic [7:0]  CODE_BULK      = 8'h10;
	localparam logic [7:0]  CODE_SECTOR    = 8'h30;
	localparam logic [7:0]  CODE_SUSPEND   = 8'hb0;
	localparam logic [7:0]  CODE_RESUME    = 8'h30;
	localparam logic [7:0]  CODE_BYP_EXIT1 = 8'h90;
	localparam logic [7:0]  CODE_BYP_EXIT2 = 8'h00;
	localparam logic [7:0]  CODE_RESET     = 8'hf0;
	localparam logic [7:0]  BYTE_ERASED    = 8'hff;
	localparam logic [7:0]  BYTE_CLEARED   = 8'h00;
	localparam int          POLL_BIT       = 7;
	localparam int          TOGGLE_BIT     = 6;
	localparam int          FAIL_BIT       = 5;
	localparam int          WINDOW_BIT     = 3;
	typedef enum logic [3:0] {
		ST_READ, ST_UNL1, ST_UNL2, ST_PROG_ARG, ST_ERASE_CMD, ST_ER_UNL1,
		ST_ER_UNL2, ST_ERASE_SEL, ST_BYP_IDLE, ST_BYP_ARG, ST_BYP_EXIT
	} cmd_state_t;
	typedef enum logic [2:0] {
		AL_IDLE, AL_PROG, AL_WINDOW, AL_PRECLR, AL_ERASE, AL_SUSP_WAIT, AL_SUSP, AL_FAIL
	} alg_state_t;
endpackage

// ---- flash_timer.sv ----
// cycle down-counter with load and expiry flag
`timescale 1ns/1ps
module flash_timer #(
	parameter int WIDTH = 24
) (
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	// control
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_count,
	input  wire logic             i_stop,
	// status
	output logic                  o_running,
	output logic                  o_expired
);
	logic [WIDTH-1:0] cnt_q;
	logic             run_q;
	assign o_running = run_q;
	assign o_expired = run_q && (cnt_q == '0);
	always_ff @(posedge i_clk) begin
		if (i_reset || i_stop) begin
			cnt_q <= '0;
			run_q <= 1'b0;
		end else if (i_load) begin
			cnt_q <= i_count;
			run_q <= 1'b1;
		end else if (run_q) begin
			if (cnt_q == '0) begin
				run_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
endmodule

// ---- flash_program_erase_sequencer.sv ----
// flash command decoder, embedded program/erase algorithm and status
`timescale 1ns/1ps
module flash_program_erase_sequencer
	import flash_seq_pkg::*;
#(
	parameter int WINDOW_CYCLES = WINDOW_CYC,
	parameter int PROG_CYCLES   = PROG_CYC_DEF,
	parameter int ERASE_CYCLES  = ERASE_CYC_DEF,
	parameter int PROG_LIMIT    = PROG_LIMIT_DEF
) (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset,
	// microcontroller bus (one-cycle strobes)
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic [7:0]  i_main_sector_selects,
	input  wire logic [3:0]  i_secondary_sector_selects,
	// array data for the addressed byte
	input  wire logic [7:0]  i_array_rdata,
	// array cell operations
	output logic             o_cell_prog,
	output logic             o_cell_erase,
	output logic             o_cell_preclear,
	output logic [7:0]       o_cell_wdata,
	output logic             o_target_secondary,
	output logic [7:0]       o_erase_main_mask,
	output logic [3:0]       o_erase_sec_mask,
	// read data and status
	output logic [7:0]       o_rdata,
	output logic             o_bypass_mode,
	output logic             o_suspended,
	output logic             o_ready_busy_pin
);
	cmd_state_t  cmd_q, cmd_d;
	alg_state_t  alg_q, alg_d;
	logic [7:0]  data_q;
	logic [11:0] paddr_q;
	logic        sec_q;
	logic [7:0]  emain_q;
	logic [3:0]  esec_q;
	logic        toggle_q;
	logic        fail_q;
	logic        byp_q;
	logic        bulk_q;
	logic [7:0]  rdata_q;
	logic [23:0] alg_cnt_q;

	// decoded bus cycles
	wire sel_main = |i_main_sector_selects;
	wire sel_sec  = |i_secondary_sector_selects;
	wire sel_any  = sel_main | sel_sec;
	wire wr_ok    = i_wr & sel_any;
	wire is_unl1  = (i_addr == ADDR_UNLOCK1) && (i_wdata == CODE_UNLOCK1);
	wire is_unl2  = (i_addr == ADDR_UNLOCK2) && (i_wdata == CODE_UNLOCK2);
	wire even_adr = ~i_addr[0];
	wire is_susp  = wr_ok & even_adr & (i_wdata == CODE_SUSPEND);
	wire is_resum = wr_ok & even_adr & (i_wdata == CODE_RESUME);
	wire is_reset = wr_ok & (i_wdata == CODE_RESET);
	// zero-to-one attempt against current array content
	wire bad_bits = |(i_wdata & ~i_array_rdata);
	wire hit_addr = (i_addr == paddr_q) && (sel_sec == sec_q);
	wire hit_sect = |(i_main_sector_selects & emain_q) | |(i_secondary_sector_selects & esec_q);
	wire alg_busy = (alg_q == AL_PROG) || (alg_q == AL_PRECLR) || (alg_q == AL_ERASE)
		|| (alg_q == AL_WINDOW) || (alg_q == AL_SUSP_WAIT);
	wire erasing  = (alg_q == AL_PRECLR) || (alg_q == AL_ERASE);
	wire cnt_zero = (alg_cnt_q == 24'h000000);
	wire sector_add = (alg_q == AL_WINDOW) && wr_ok && (i_wdata == CODE_SECTOR);
	wire win_exp;
	wire start_prog;
	wire start_bulk;
	wire start_sect;

	flash_timer #(
		.WIDTH(24)
	) u_window (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_load    (start_sect | sector_add),
		.i_count   (24'(WINDOW_CYCLES)),
		.i_stop    (alg_q != AL_WINDOW && !start_sect),
		.o_running (),
		.o_expired (win_exp)
	);

	// command sequencer
	assign start_prog = wr_ok && !alg_busy && alg_q != AL_SUSP
		&& (cmd_q == ST_PROG_ARG || cmd_q == ST_BYP_ARG);
	assign start_bulk = wr_ok && cmd_q == ST_ER_UNL2 && i_addr == ADDR_UNLOCK1
		&& i_wdata == CODE_BULK;
	assign start_sect = wr_ok && cmd_q == ST_ER_UNL2 && i_wdata == CODE_SECTOR;

	always_comb begin
		cmd_d = cmd_q;
		if (wr_ok && (alg_busy || alg_q == AL_SUSP)) begin
			cmd_d = ST_READ;
		end else if (wr_ok) begin
			case (cmd_q)
				ST_READ:      cmd_d = is_unl1 ? ST_UNL1 : ST_READ;
				ST_UNL1:      cmd_d = is_unl2 ? ST_UNL2 : ST_READ;
				ST_UNL2: begin
					if (i_wdata == CODE_PROGRAM) cmd_d = ST_PROG_ARG;
					else if (i_wdata == CODE_ERASE) cmd_d = ST_ERASE_CMD;
					else if (i_wdata == CODE_BYPASS) cmd_d = ST_BYP_IDLE;
					else cmd_d = ST_READ;
				end
				ST_PROG_ARG:  cmd_d = ST_READ;
				ST_ERASE_CMD: cmd_d = is_unl1 ? ST_ER_UNL1 : ST_READ;
				ST_ER_UNL1:   cmd_d = is_unl2 ? ST_ER_UNL2 : ST_READ;
				ST_ER_UNL2:   cmd_d = ST_READ;
				ST_ERASE_SEL: cmd_d = ST_READ;
				ST_BYP_IDLE: begin
					if (i_wdata == CODE_PROGRAM) cmd_d = ST_BYP_ARG;
					else if (i_wdata == CODE_BYP_EXIT1) cmd_d = ST_BYP_EXIT;
					else cmd_d = ST_BYP_IDLE;
				end
				ST_BYP_ARG:   cmd_d = ST_BYP_IDLE;
				ST_BYP_EXIT:  cmd_d = (i_wdata == CODE_BYP_EXIT2) ? ST_READ : ST_BYP_IDLE;
				default:      cmd_d = ST_READ;
			endcase
		end
		if (cmd_q == ST_ER_UNL1 && wr_ok && !is_unl2) cmd_d = byp_q ? ST_BYP_IDLE : ST_READ;
	end

	// embedded algorithm
	always_comb begin
		alg_d = alg_q;
		case (alg_q)
			AL_IDLE: begin
				if (start_prog) alg_d = bad_bits ? AL_FAIL : AL_PROG;
				else if (start_bulk) alg_d = AL_PRECLR;
				else if (start_sect) alg_d = AL_WINDOW;
			end
			AL_PROG: begin
				if (cnt_zero) alg_d = AL_IDLE;
			end
			AL_WINDOW: begin
				if (is_susp) alg_d = AL_SUSP_WAIT;
				else if (wr_ok && !sector_add && !is_resum) alg_d = AL_IDLE;
				else if (win_exp) alg_d = AL_PRECLR;
			end
			AL_PRECLR: begin
				if (is_reset && !bulk_q) alg_d = AL_IDLE;
				else if (is_susp && !bulk_q) alg_d = AL_SUSP_WAIT;
				else if (cnt_zero) alg_d = AL_ERASE;
			end
			AL_ERASE: begin
				if (is_reset && !bulk_q) alg_d = AL_IDLE;
				else if (is_susp && !bulk_q) alg_d = AL_SUSP_WAIT;
				else if (cnt_zero) alg_d = AL_IDLE;
			end
			AL_SUSP_WAIT: begin
				if (cnt_zero) alg_d = AL_SUSP;
			end
			AL_SUSP: begin
				if (is_resum) alg_d = AL_ERASE;
				else if (is_reset) alg_d = AL_IDLE;
			end
			AL_FAIL: begin
				if (is_reset) alg_d = AL_IDLE;
			end
			default: alg_d = AL_IDLE;
		endcase
	end

	// status byte for a read during an algorithm
	wire       in_target = (alg_q == AL_PROG || alg_q == AL_FAIL) ? hit_addr : hit_sect;
	wire [7:0] status_b  = {(alg_q == AL_PROG) ? ~data_q[7] : 1'b0,
		toggle_q, fail_q, 1'b0, (alg_q != AL_WINDOW), 3'b000};
	wire       show_stat = in_target && (alg_busy || alg_q == AL_FAIL);

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			cmd_q     <= ST_READ;
			alg_q     <= AL_IDLE;
			data_q    <= 8'h00;
			paddr_q   <= 12'h000;
			sec_q     <= 1'b0;
			emain_q   <= 8'h00;
			esec_q    <= 4'h0;
			toggle_q  <= 1'b0;
			fail_q    <= 1'b0;
			byp_q     <= 1'b0;
			bulk_q    <= 1'b0;
			rdata_q   <= 8'h00;
			alg_cnt_q <= 24'h000000;
		end else begin
			cmd_q <= cmd_d;
			alg_q <= alg_d;
			byp_q <= (cmd_d == ST_BYP_IDLE) || (cmd_d == ST_BYP_ARG) || (cmd_d == ST_BYP_EXIT);
			if (start_prog && alg_q == AL_IDLE) begin
				data_q  <= i_wdata;
				paddr_q <= i_addr;
				sec_q   <= sel_sec;
				fail_q  <= bad_bits;
				alg_cnt_q <= 24'(PROG_CYCLES);
			end else if ((start_bulk || start_sect) && alg_q == AL_IDLE) begin
				bulk_q  <= start_bulk;
				fail_q  <= 1'b0;
				emain_q <= start_bulk ? (sel_main ? 8'hff : 8'h00) : i_main_sector_selects;
				esec_q  <= start_bulk ? (sel_sec ? 4'hf : 4'h0) : i_secondary_sector_selects;
				alg_cnt_q <= 24'(ERASE_CYCLES);
			end else if (sector_add) begin
				emain_q <= emain_q | i_main_sector_selects;
				esec_q  <= esec_q | i_secondary_sector_selects;
			end else if (alg_d == AL_SUSP_WAIT && alg_q != AL_SUSP_WAIT) begin
				alg_cnt_q <= 24'(SUSP_CYC);
			end else if (alg_q == AL_PRECLR && alg_d == AL_ERASE) begin
				alg_cnt_q <= 24'(ERASE_CYCLES);
			end else if (alg_q == AL_SUSP && alg_d == AL_ERASE) begin
				alg_cnt_q <= 24'(ERASE_CYCLES);
			end else if (!cnt_zero && alg_q != AL_SUSP) begin
				alg_cnt_q <= alg_cnt_q - 24'h000001;
			end
			if (alg_q == AL_PROG && cnt_zero && alg_cnt_q == 24'(PROG_LIMIT)) begin
				fail_q <= 1'b1;
			end
			if (is_reset && (alg_q == AL_FAIL || alg_q == AL_SUSP)) begin
				fail_q <= 1'b0;
			end
			if (alg_q == AL_IDLE && alg_d == AL_IDLE) begin
				emain_q <= alg_q == AL_IDLE ? emain_q : 8'h00;
			end
			if (i_rd && show_stat && alg_busy) begin
				toggle_q <= ~toggle_q;
			end
			if (i_rd) begin
				if (show_stat) rdata_q <= status_b;
				else if (alg_q == AL_SUSP && hit_sect) rdata_q <= BYTE_ERASED ^ 8'h5a;
				else rdata_q <= i_array_rdata;
			end
		end
	end

	// cell operations: program ands data into cells, erase sets ones
	assign o_cell_prog        = (alg_q == AL_PROG) && cnt_zero;
	assign o_cell_wdata       = (alg_q == AL_PRECLR) ? BYTE_CLEARED : data_q;
	assign o_cell_preclear    = (alg_q == AL_PRECLR) && cnt_zero;
	assign o_cell_erase       = (alg_q == AL_ERASE) && cnt_zero;
	assign o_target_secondary = sec_q;
	assign o_erase_main_mask  = emain_q;
	assign o_erase_sec_mask   = esec_q;
	assign o_rdata            = rdata_q;
	assign o_bypass_mode      = byp_q;
	assign o_suspended        = (alg_q == AL_SUSP);
	assign o_ready_busy_pin   = ~alg_busy;
	wire unused_ok = erasing;
endmodule

// ---- flash_array_model.sv ----
// flash cell array model answering the sequencer's cell operations
`timescale 1ns/1ps
module flash_array_model (
	// clock and bus
	input  wire logic        i_clk,
	input  wire logic        i_wr,
	input  wire logic [11:0] i_addr,
	// cell operations
	input  wire logic        i_cell_prog,
	input  wire logic        i_cell_erase,
	input  wire logic        i_cell_preclear,
	input  wire logic [7:0]  i_cell_wdata,
	// array data
	output logic [7:0]       o_array_rdata
);
	logic [7:0] mem_q [16];
	logic [3:0] paddr_q;
	assign o_array_rdata = mem_q[i_addr[3:0]];
	initial foreach (mem_q[i]) mem_q[i] = 8'hff;
	always @(posedge i_clk) begin
		if (i_wr) paddr_q <= i_addr[3:0];
		if (i_cell_prog) mem_q[paddr_q] <= mem_q[paddr_q] & i_cell_wdata;
		if (i_cell_preclear) foreach (mem_q[i]) mem_q[i] <= 8'h00;
		if (i_cell_erase) foreach (mem_q[i]) mem_q[i] <= 8'hff;
	end
endmodule

// ---- flash_seq_asserts.sv ----
// port checks for the flash sequencer
`timescale 1ns/1ps
module flash_seq_asserts (
	input wire logic        i_clk,
	input wire logic        i_reset,
	input wire logic        i_wr,
	input wire logic        i_rd,
	input wire logic [11:0] i_addr,
	input wire logic [7:0]  i_wdata,
	input wire logic [7:0]  i_main_sector_selects,
	input wire logic [3:0]  i_secondary_sector_selects,
	input wire logic        o_cell_prog,
	input wire logic        o_cell_erase,
	input wire logic        o_cell_preclear,
	input wire logic [7:0]  o_rdata,
	input wire logic        o_bypass_mode,
	input wire logic        o_suspended,
	input wire logic        o_ready_busy_pin
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	wire logic sel;
	wire logic rdy;
	assign sel = |{i_main_sector_selects, i_secondary_sector_selects};
	assign rdy = o_ready_busy_pin;
	sequence unlock_s;
		i_wr && sel && i_addr == 12'h555 && i_wdata == 8'haa
		##1 i_wr && sel && i_addr == 12'haaa && i_wdata == 8'h55;
	endsequence
	bypass_entry_a: assert property (rdy && !o_bypass_mode && !o_suspended && !$past(i_wr)
		##0 unlock_s ##1 i_wr && sel && i_wdata == 8'h20 |=> o_bypass_mode)
		else $error("bypass mode not entered");
	bypass_exit_a: assert property (o_bypass_mode && rdy && i_wr && sel && i_wdata == 8'h90
		##1 i_wr && sel && rdy && i_wdata == 8'h00 |=> !o_bypass_mode)
		else $error("bypass mode not left");
	bypass_prog_a: assert property (o_bypass_mode && rdy && i_wr && sel && i_wdata == 8'ha0
		##1 i_wr && sel |=> !rdy [*2] ##[0:300] o_cell_prog)
		else $error("bypass program not run");
	reset_idle_a: assert property ($fell(i_reset) |-> rdy && !o_bypass_mode && !o_suspended)
		else $error("not idle after reset");
	pulse_excl_a: assert property ($onehot0({o_cell_prog, o_cell_erase, o_cell_preclear}))
		else $error("cell operations overlap");
	preclear_busy_a: assert property (o_cell_preclear || o_cell_erase |-> !rdy)
		else $error("cell clear while ready");
	suspend_ready_a: assert property (o_suspended |-> rdy && !o_cell_erase)
		else $error("suspended but busy");
	toggle_flip_a: assert property ((i_rd && sel && !rdy) ##2 (i_rd && sel && !rdy)
		|=> o_rdata[6] != $past(o_rdata[6], 2))
		else $error("toggle bit did not flip");
	cover property (o_cell_prog);
	cover property (o_cell_erase);
	cover property (o_suspended);
endmodule

// ---- flash_program_erase_sequencer_tb.sv ----
// self-checking bench for the flash sequencer
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb;
	import flash_seq_pkg::*;
	logic        i_clk = 1'b0;
	logic        i_reset = 1'b1;
	logic        i_wr = 1'b0;
	logic        i_rd = 1'b0;
	logic [11:0] i_addr = 12'h000;
	logic [7:0]  i_wdata = 8'h00;
	logic [7:0]  main_sel = 8'h01;
	logic [3:0]  sec_sel = 4'h0;
	logic [7:0]  arr, rdata, wdat, d;
	logic        prog, erase, preclr, tsec, byp, susp, rb;
	logic        rd_pend = 1'b0;
	logic [11:0] a;
	logic [15:0] exp_q[$];
	int          mismatches = 0;
	int          tests_run = 0;
	always #5 i_clk = ~i_clk;
	flash_program_erase_sequencer #(.WINDOW_CYCLES(50), .PROG_CYCLES(5), .ERASE_CYCLES(200)) dut_u (
		.i_clk, .i_reset, .i_wr, .i_rd, .i_addr, .i_wdata,
		.i_main_sector_selects(main_sel), .i_secondary_sector_selects(sec_sel),
		.i_array_rdata(arr), .o_cell_prog(prog), .o_cell_erase(erase),
		.o_cell_preclear(preclr), .o_cell_wdata(wdat), .o_target_secondary(tsec),
		.o_erase_main_mask(), .o_erase_sec_mask(), .o_rdata(rdata),
		.o_bypass_mode(byp), .o_suspended(susp), .o_ready_busy_pin(rb));
	flash_array_model arr_u (.i_clk, .i_wr, .i_addr, .i_cell_prog(prog), .i_cell_erase(erase),
		.i_cell_preclear(preclr), .i_cell_wdata(wdat), .o_array_rdata(arr));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] wa, input logic [7:0] wd);
		i_wr <= 1'b1;
		i_addr <= wa;
		i_wdata <= wd;
		@(posedge i_clk);
	endtask
	task automatic idle(input int n);
		i_wr <= 1'b0;
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic rd(input logic [11:0] ra, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back({m, e});
		i_wr <= 1'b0;
		i_rd <= 1'b1;
		i_addr <= ra;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	task automatic cmd(input logic [7:0] c, input logic [11:0] ca);
		wr(12'h555, 8'haa);
		wr(12'haaa, 8'h55);
		wr(ca, c);
	endtask
	task automatic wait_rdy();
		for (int n = 0; n < 3000 && rb !== 1'b1; n++) @(posedge i_clk);
		#1;
		chk("ready", 8'h01, {7'h0, rb});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	always @(posedge i_clk) begin
		if (rd_pend) begin
			chk("rdata", exp_q[0][7:0] & exp_q[0][15:8], rdata & exp_q[0][15:8]);
			void'(exp_q.pop_front());
		end
		rd_pend <= i_rd;
	end
	initial begin
		#100us;
		mismatches++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'he6da));
		repeat (4) @(posedge i_clk);
		i_reset <= 1'b0;
		idle(1);
		a = {8'h01, 4'($urandom())};
		d = 8'($urandom()) & 8'h7f;
		cmd(8'ha0, 12'h555);
		wr(a, d);
		rd(a, {~d[7], 7'h0}, 8'ha0);
		rd(a, {~d[7], 1'b1, 6'h0}, 8'he0);
		wait_rdy();
		rd(a, d, 8'hff);
		$display("program test done");
		cmd(8'ha0, 12'h555);
		wr(a, 8'hff);
		idle(10);
		rd(a, 8'h20, 8'h20);
		wr(12'h000, 8'hf0);
		idle(30);
		cmd(8'h80, 12'h555);
		wr(12'h555, 8'haa);
		wr(12'haaa, 8'h77);
		idle(30);
		rd(a, d, 8'hff);
		$display("failure and abort test done");
		main_sel <= 8'h00;
		sec_sel <= 4'h2;
		cmd(8'h20, 12'h555);
		wr(12'h555, 8'h80);
		idle(3);
		chk("bypass", 8'h03, {6'h0, byp, rb});
		for (int i = 0; i < 2; i++) begin
			wr(12'h000, 8'ha0);
			wr(a + 12'(i + 1), 8'h5a);
			idle(2);
			chk("target", 8'h01, {7'h0, tsec});
			wait_rdy();
		end
		wr(12'h123, 8'h90);
		wr(12'h456, 8'h00);
		idle(1);
		chk("bypass", 8'h00, {7'h0, byp});
		rd(a + 12'h1, 8'h5a, 8'hff);
		$display("bypass test done");
		main_sel <= 8'h01;
		sec_sel <= 4'h0;
		cmd(8'h80, 12'h555);
		cmd(8'h10, 12'h555);
		wr(12'h000, 8'hf0);
		idle(3);
		chk("ready", 8'h00, {7'h0, rb});
		wait_rdy();
		rd(a + 12'h1, 8'hff, 8'hff);
		$display("bulk erase test done");
		cmd(8'h80, 12'h555);
		cmd(8'h30, 12'h010);
		rd(12'h010, 8'h00, 8'h88);
		main_sel <= 8'h02;
		wr(12'h020, 8'h30);
		main_sel <= 8'h01;
		idle(60);
		rd(12'h010, 8'h08, 8'h88);
		wr(12'h010, 8'hb0);
		idle(12);
		chk("suspend", 8'h03, {6'h0, susp, rb});
		rd(12'h010, 8'ha5, 8'hff);
		wr(12'h010, 8'h30);
		idle(2);
		chk("suspend", 8'h00, {6'h0, susp, rb});
		wait_rdy();
		rd(12'h010, 8'hff, 8'hff);
		idle(2);
		$display("sector erase test done");
		wrap_up();
	end
endmodule
bind flash_program_erase_sequencer flash_seq_asserts chk_u (.i_clk, .i_reset, .i_wr, .i_rd,
	.i_addr, .i_wdata, .i_main_sector_selects, .i_secondary_sector_selects, .o_cell_prog,
	.o_cell_erase, .o_cell_preclear, .o_rdata, .o_bypass_mode, .o_suspended, .o_ready_busy_pin);
